// >>> hw/cfg_loader_pkg.sv
// constants, state encoding and state record for the configuration word loader
package cfg_loader_pkg;
	// eeprom word byte addresses, read in ascending order
	localparam logic [7:0] EE_CAP     = 8'h0c;
	localparam logic [7:0] EE_MARGIN  = 8'h0e;
	localparam logic [7:0] EE_NOM     = 8'h10;
	localparam logic [7:0] EE_EMPH    = 8'h12;
	localparam logic [7:0] EE_LAT     = 8'h14;
	localparam logic [7:0] EE_PHY4_LO = 8'h16;
	localparam logic [7:0] EE_PHY4_HI = 8'h18;
	localparam logic [7:0] EE_PHY5_LO = 8'h1a;
	localparam logic [7:0] EE_PHY5_HI = 8'h1c;
	localparam logic [7:0] EE_DELTA   = 8'h1e;
	localparam logic [7:0] EE_FTS     = 8'h20;
	localparam logic [7:0] EE_STEP    = 8'h02;
	// bit positions inside the per-port configuration images
	localparam int CC_SURPRISE  = 19;
	localparam int TL_DSEL      = 1;
	localparam int TL_ABORT     = 2;
	localparam int TL_4KB       = 3;
	localparam int TL_GNTIDLE   = 7;
	localparam int TL_VCFLG     = 12;
	localparam int TL_LLC_LSB   = 26;
	localparam int TL_GEN2      = 31;
	localparam int E4_LTR       = 12;
	localparam int E4_OBFF      = 18;
	localparam int DRV_LSB      = 16;
	localparam int HALF_DLT_LSB = 15;
	localparam int DELTA_LSB    = 20;
	localparam int BUF_LSB      = 16;
	// axi4-lite register map and responses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST   = 8'h08;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLV   = 2'b10;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_DONE = 3'b100
	} load_st_t;
	typedef struct packed {
		load_st_t    st;
		logic        req;
		logic [7:0]  addr;
		logic [15:0] last;
		logic [31:0] cc;
		logic [31:0] tl;
		logic [31:0] e4;
		logic [31:0] r94;
		logic [31:0] r74;
		logic [31:0] r78;
		logic [31:0] r7c;
		logic [31:0] r90;
		logic [31:0] r84;
		logic [31:0] r88;
		logic [31:0] r98;
		logic [5:0]  intx;
		logic [7:0]  fts;
		logic        awready;
		logic        wready;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} loader_state_t;
endpackage

// >>> hw/eeprom_config_word_loader.sv
// eeprom configuration word loader with axi4-lite control and status
// Summary of operation
// RULE1: word 0Ch is a capability word copied to all six ports
// RULE2: capability bit 12 loads link capability CCh bit 19, surprise down
// RULE3: capability bit 13 loads 8Ch bit 1, data select read/write
// RULE4: capability bit 14 loads E4h bit 12, LTR enable
// RULE5: capability bit 15 loads 8Ch bit 3, 4KB boundary check
// RULE6: word 0Eh bits 14:0 load three margin drive levels at 94h
// RULE7: word 0Eh bit 15 loads E4h bit 18, OBFF enable
// RULE8: word 10h bits 14:0 load nominal drive levels at 74h 30:16
// RULE9: word 10h bit 15 loads 8Ch bit 31, second gen speed select
// RULE10: word 12h bits 14:0 load post emphasis values at 78h 30:16
// RULE11: word 12h bit 15 loads 3Ch bit 8 on ports 1 to 5 only
// RULE12: word 14h loads transmit latency and receiver detect into 7Ch
// RULE13: word 14h bits 11:7 load half swing delta at 90h 19:15
// RULE14: word 14h bits 12,13,14 load 8Ch bits 2,7,12
// RULE15: words 16h and 18h fill low and high halves of 84h
// RULE16: word 1Ah fills 88h 15:0, word 1Ch low byte fills 88h 23:16
// RULE17: word 1Ch high byte loads reference clock buffer control 98h 23:16
// RULE18: word 1Eh bits 11:0 load six delta fields at 90h 31:20
// RULE19: word 1Eh bits 15:12 load link layer parameter 8Ch 29:26
// RULE20: word 20h low byte loads port 0 fast training count at 78h
// RULE21: words read ascending after reset; ports held until all loaded
// RULE22: eeprom returns each requested word with the documented layout
`timescale 1ns/10ps
module eeprom_config_word_loader
	import cfg_loader_pkg::*;
(
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// eeprom word read port
	output logic             ee_rd_req,
	output logic [7:0]       ee_rd_addr,
	input  wire logic        ee_rd_valid,
	input  wire logic [15:0] ee_rd_data,
	// per-port configuration images, shared by ports 0 to 5
	output logic [31:0]      cfg_link_cap_img,
	output logic [31:0]      cfg_tl_ctrl_img,
	output logic [31:0]      cfg_cap_en_img,
	output logic [31:0]      cfg_margin_img,
	output logic [31:0]      cfg_nom_drive_img,
	output logic [31:0]      cfg_emphasis_img,
	output logic [31:0]      cfg_phy_param2_img,
	output logic [31:0]      cfg_phy_param3_img,
	output logic [31:0]      cfg_phy4_img,
	output logic [31:0]      cfg_phy5_img,
	output logic [31:0]      cfg_buffer_img,
	// port specific values
	output logic [5:0]       irq_pin_req,
	output logic [7:0]       port0_fts,
	output logic             cfg_ready,
	// axi4-lite slave
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);

	loader_state_t s;
	loader_state_t s_nxt;
	logic          ld_take;
	logic          busy;

	assign busy    = (s.st == ST_READ);
	assign ld_take = s.req && ee_rd_valid;

	// next state: loader walk, then the bus slave
	always_comb
	begin
		s_nxt = s;
		if (ld_take)
		begin
			s_nxt.last = ee_rd_data;
			case (s.addr)
				EE_CAP:
				begin
					s_nxt.cc[CC_SURPRISE] = ee_rd_data[12]; // RULE1 RULE2
					s_nxt.tl[TL_DSEL]     = ee_rd_data[13]; // RULE3
					s_nxt.e4[E4_LTR]      = ee_rd_data[14]; // RULE4
					s_nxt.tl[TL_4KB]      = ee_rd_data[15]; // RULE5
				end
				EE_MARGIN:
				begin
					s_nxt.r94[14:0]   = ee_rd_data[14:0]; // RULE6
					s_nxt.e4[E4_OBFF] = ee_rd_data[15]; // RULE7
				end
				EE_NOM:
				begin
					s_nxt.r74[DRV_LSB +: 15] = ee_rd_data[14:0]; // RULE8
					s_nxt.tl[TL_GEN2]        = ee_rd_data[15]; // RULE9
				end
				EE_EMPH:
				begin
					s_nxt.r78[DRV_LSB +: 15] = ee_rd_data[14:0]; // RULE10
					// port 0 is upstream and never requests a legacy pin
					s_nxt.intx = {{5{ee_rd_data[15]}}, 1'b0}; // RULE11
				end
				EE_LAT:
				begin
					s_nxt.r7c[6:0]                = ee_rd_data[6:0]; // RULE12
					s_nxt.r90[HALF_DLT_LSB +: 5]  = ee_rd_data[11:7]; // RULE13
					s_nxt.tl[TL_ABORT]            = ee_rd_data[12]; // RULE14
					s_nxt.tl[TL_GNTIDLE]          = ee_rd_data[13]; // RULE14
					s_nxt.tl[TL_VCFLG]            = ee_rd_data[14]; // RULE14
				end
				EE_PHY4_LO:
					s_nxt.r84[15:0] = ee_rd_data; // RULE15
				EE_PHY4_HI:
					s_nxt.r84[31:16] = ee_rd_data; // RULE15
				EE_PHY5_LO:
					s_nxt.r88[15:0] = ee_rd_data; // RULE16
				EE_PHY5_HI:
				begin
					s_nxt.r88[23:16]         = ee_rd_data[7:0]; // RULE16
					s_nxt.r98[BUF_LSB +: 8]  = ee_rd_data[15:8]; // RULE17
				end
				EE_DELTA:
				begin
					s_nxt.r90[DELTA_LSB +: 12] = ee_rd_data[11:0]; // RULE18
					s_nxt.tl[TL_LLC_LSB +: 4]  = ee_rd_data[15:12]; // RULE19
				end
				EE_FTS:
					s_nxt.fts = ee_rd_data[7:0]; // RULE20
				default:
					s_nxt.last = ee_rd_data;
			endcase
			// ascending walk; ports released only after the last word
			if (s.addr == EE_FTS)
			begin
				s_nxt.req = 1'b0; // RULE21
				s_nxt.st  = ST_DONE; // RULE21
			end
			else
				s_nxt.addr = 8'(s.addr + EE_STEP); // RULE21
		end

		// write channel: address and data taken in either order
		if (awvalid && s.awready)
		begin
			s_nxt.awready = 1'b0;
			s_nxt.awaddr  = awaddr;
		end
		if (wvalid && s.wready)
		begin
			s_nxt.wready = 1'b0;
			s_nxt.wdata  = wdata;
			s_nxt.wstrb  = wstrb;
		end
		if (!s.awready && !s.wready && !s.bvalid)
		begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			if (s.awaddr == REG_CTRL)
			begin
				// a reload during a walk would interleave two passes, so it is ignored
				if (s.wstrb[0] && s.wdata[0] && !busy)
				begin
					s_nxt.st   = ST_READ;
					s_nxt.req  = 1'b1;
					s_nxt.addr = EE_CAP;
				end
			end
			else if (s.awaddr == REG_STATUS || s.awaddr == REG_LAST)
				s_nxt.bresp = RESP_OKAY;
			else
				s_nxt.bresp = RESP_SLV;
		end
		if (s.bvalid && bready)
		begin
			s_nxt.bvalid  = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready  = 1'b1;
		end

		// read channel: one outstanding read, answer one cycle after address
		if (arvalid && s.arready)
		begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid  = 1'b1;
			s_nxt.rresp   = RESP_OKAY;
			if (araddr == REG_CTRL)
				s_nxt.rdata = 32'h0000_0000;
			else if (araddr == REG_STATUS)
				s_nxt.rdata = {16'h0000, s.addr, 5'h00, s.st};
			else if (araddr == REG_LAST)
				s_nxt.rdata = {16'h0000, s.last};
			else
			begin
				s_nxt.rdata = 32'h0000_0000;
				s_nxt.rresp = RESP_SLV;
			end
		end
		if (s.rvalid && rready)
		begin
			s_nxt.rvalid  = 1'b0;
			s_nxt.arready = 1'b1;
		end
	end

	// state register; the walk starts by itself when reset is released
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s         <= '0;
			s.st      <= ST_READ;
			s.req     <= 1'b1;
			s.addr    <= EE_CAP;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
		end
		else if (ce)
			s <= s_nxt;
	end

	// outputs are taken straight from the state record, except cfg_ready, which is decoded from s.st
	assign ee_rd_req          = s.req;
	assign ee_rd_addr         = s.addr;
	assign cfg_link_cap_img   = s.cc;
	assign cfg_tl_ctrl_img    = s.tl;
	assign cfg_cap_en_img     = s.e4;
	assign cfg_margin_img     = s.r94;
	assign cfg_nom_drive_img  = s.r74;
	assign cfg_emphasis_img   = s.r78;
	assign cfg_phy_param2_img = s.r7c;
	assign cfg_phy_param3_img = s.r90;
	assign cfg_phy4_img       = s.r84;
	assign cfg_phy5_img       = s.r88;
	assign cfg_buffer_img     = s.r98;
	assign irq_pin_req        = s.intx;
	assign port0_fts          = s.fts;
	assign cfg_ready          = (s.st == ST_DONE); // RULE21
	assign awready            = s.awready;
	assign wready             = s.wready;
	assign bvalid             = s.bvalid;
	assign bresp              = s.bresp;
	assign arready            = s.arready;
	assign rvalid             = s.rvalid;
	assign rdata              = s.rdata;
	assign rresp              = s.rresp;

	// checks on the loader walk and the loaded images
	sequence word_taken(logic [7:0] a);
		ce && ee_rd_req && ee_rd_valid && ee_rd_addr == a;
	endsequence

	sequence walk_steps;
		ce && ee_rd_req && ee_rd_valid && ee_rd_addr != EE_FTS;
	endsequence

	walk_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
		walk_steps |=> ee_rd_req && ee_rd_addr == 8'($past(ee_rd_addr) + EE_STEP))
		else $error("eeprom words not read in ascending order");

	ready_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
		word_taken(EE_FTS) |=> cfg_ready && !ee_rd_req && port0_fts == $past(ee_rd_data[7:0]))
		else $error("ports not released with the last word");

	surprise_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		word_taken(EE_CAP) |=> cfg_link_cap_img[CC_SURPRISE] == $past(ee_rd_data[12]))
		else $error("surprise down enable not loaded");

	tl_cap_bits_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		word_taken(EE_CAP) |=> cfg_tl_ctrl_img[TL_4KB] == $past(ee_rd_data[15])
			&& cfg_tl_ctrl_img[TL_DSEL] == $past(ee_rd_data[13]))
		else $error("capability word bits not loaded into 8Ch");

	margin_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		word_taken(EE_MARGIN) |=> cfg_margin_img[14:0] == $past(ee_rd_data[14:0])
			&& cfg_cap_en_img[E4_OBFF] == $past(ee_rd_data[15]))
		else $error("margin word not loaded");

	intx_ports_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
		word_taken(EE_EMPH) |=> irq_pin_req[0] == 1'b0
			&& irq_pin_req[5:1] == {5{$past(ee_rd_data[15])}})
		else $error("interrupt pin request wrong for a port");

	phy4_high_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
		word_taken(EE_PHY4_HI) |=> cfg_phy4_img[31:16] == $past(ee_rd_data)
			&& $stable(cfg_phy4_img[15:0]))
		else $error("upper half of 84h not loaded");

	delta_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
		word_taken(EE_DELTA) |=> cfg_phy_param3_img[DELTA_LSB +: 12] == $past(ee_rd_data[11:0])
			&& cfg_tl_ctrl_img[TL_LLC_LSB +: 4] == $past(ee_rd_data[15:12]))
		else $error("delta fields not loaded");

	phy5_split_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
		word_taken(EE_PHY5_HI) |=> cfg_buffer_img[BUF_LSB +: 8] == $past(ee_rd_data[15:8])
			&& cfg_phy5_img[23:16] == $past(ee_rd_data[7:0]))
		else $error("word 1Ch not split correctly");

	// remaining word fields; each one is checked on the edge after its word is taken
	ltr_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		word_taken(EE_CAP) |=> cfg_cap_en_img[E4_LTR] == $past(ee_rd_data[14]))
		else $error("ltr enable not loaded");

	nominal_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
		word_taken(EE_NOM) |=> cfg_nom_drive_img[DRV_LSB +: 15] == $past(ee_rd_data[14:0]))
		else $error("nominal drive levels not loaded");

	gen2_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		word_taken(EE_NOM) |=> cfg_tl_ctrl_img[TL_GEN2] == $past(ee_rd_data[15]))
		else $error("second gen speed select not loaded");

	emphasis_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
		word_taken(EE_EMPH) |=> cfg_emphasis_img[DRV_LSB +: 15] == $past(ee_rd_data[14:0]))
		else $error("post emphasis values not loaded");

	latency_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
		word_taken(EE_LAT) |=> cfg_phy_param2_img[6:0] == $past(ee_rd_data[6:0]))
		else $error("latency and receiver detect not loaded");

	half_delta_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
		word_taken(EE_LAT) |=> cfg_phy_param3_img[HALF_DLT_LSB +: 5] == $past(ee_rd_data[11:7]))
		else $error("half swing delta not loaded");

	arbiter_bits_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		word_taken(EE_LAT) |=> cfg_tl_ctrl_img[TL_ABORT] == $past(ee_rd_data[12])
			&& cfg_tl_ctrl_img[TL_GNTIDLE] == $past(ee_rd_data[13])
			&& cfg_tl_ctrl_img[TL_VCFLG] == $past(ee_rd_data[14]))
		else $error("arbiter control bits not loaded");

	phy4_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
		word_taken(EE_PHY4_LO) |=> cfg_phy4_img[15:0] == $past(ee_rd_data))
		else $error("lower half of 84h not loaded");

	phy5_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
		word_taken(EE_PHY5_LO) |=> cfg_phy5_img[15:0] == $past(ee_rd_data))
		else $error("lower half of 88h not loaded");

	// walk control: a reload request mid-walk must not restart it, ports stay held
	walk_no_restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
		ee_rd_req && ee_rd_addr != EE_CAP |=> ee_rd_addr != EE_CAP)
		else $error("walk restarted while still reading");

	ready_held_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
		ee_rd_req |-> !cfg_ready)
		else $error("ports released while words are pending");

	// a low enable must hold the read request and address, cfg_ready, bvalid and rvalid where they were
	enable_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ce |=> $stable(ee_rd_addr) && $stable(ee_rd_req) && $stable(cfg_ready) && $stable(bvalid) && $stable(rvalid))
		else $error("state moved while the enable was low");

	// bus slave: the answer follows the address, readies return after the response
	sequence read_taken;
		ce && arvalid && arready;
	endsequence

	sequence write_done;
		ce && bvalid && bready;
	endsequence

	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		read_taken |=> rvalid && !arready)
		else $error("read answer not given after the address");

	read_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rvalid && rready |=> !rvalid && arready)
		else $error("read channel not released after the answer");

	write_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		write_done |=> !bvalid && awready && wready)
		else $error("write channel not released after the response");

endmodule

// >>> testbench/eeprom_model.sv
// eeprom model answering word reads, promptly or every other cycle
`timescale 1ns/10ps
module eeprom_model (
	// clock and test controls
	input  wire logic        aclk,
	input  wire logic        slow,
	input  wire logic        flip,
	// word read port
	input  wire logic        ee_rd_req,
	input  wire logic [7:0]  ee_rd_addr,
	output logic             ee_rd_valid,
	output logic [15:0]      ee_rd_data
);
	logic        tog_r = 1'b0;
	logic [15:0] last_r = 16'h0000;
	// alternate-cycle stall when slow, so the loader has to wait for data
	always @(posedge aclk)
	begin
		tog_r <= ~tog_r;
		if (ee_rd_valid)
			last_r <= ee_rd_data;
	end
	assign ee_rd_valid = ee_rd_req && (!slow || tog_r);
	// idle data is the inverse of the last word, so a stale value never matches
	assign ee_rd_data = ee_rd_valid ? ({~ee_rd_addr, ee_rd_addr} ^ {16{flip}}) : ~last_r;
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the configuration word loader
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
	import cfg_loader_pkg::*;
;
	logic        aclk = 1'b0, aresetn, ce, slow, flip, ee_rd_req, ee_rd_valid, cfg_ready;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  ee_rd_addr, awaddr, araddr, port0_fts;
	logic [15:0] ee_rd_data;
	logic [31:0] wdata, rdata, cfg_link_cap_img, cfg_tl_ctrl_img, cfg_cap_en_img, cfg_margin_img;
	logic [31:0] cfg_nom_drive_img, cfg_emphasis_img, cfg_phy_param2_img, cfg_phy_param3_img;
	logic [31:0] cfg_phy4_img, cfg_phy5_img, cfg_buffer_img, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [5:0]  irq_pin_req;
	logic [7:0]  taken[$];
	int          num_errors = 0, checks_done = 0;
	always #5 aclk = ~aclk;
	eeprom_config_word_loader eeprom_config_word_loader_i (.aclk, .aresetn, .ce, .ee_rd_req, .ee_rd_addr,
		.ee_rd_valid, .ee_rd_data, .cfg_link_cap_img, .cfg_tl_ctrl_img, .cfg_cap_en_img, .cfg_margin_img,
		.cfg_nom_drive_img, .cfg_emphasis_img, .cfg_phy_param2_img, .cfg_phy_param3_img, .cfg_phy4_img,
		.cfg_phy5_img, .cfg_buffer_img, .irq_pin_req, .port0_fts, .cfg_ready, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp);
	eeprom_model eeprom_model_i (.aclk, .slow, .flip, .ee_rd_req, .ee_rd_addr, .ee_rd_valid, .ee_rd_data);
	// log every word address the loader actually takes
	always @(posedge aclk)
		if (aresetn && ce && ee_rd_req && ee_rd_valid)
			taken.push_back(ee_rd_addr);
	function automatic logic [15:0] w(input logic [7:0] a, input logic f);
		return {~a, a} ^ {16{f}};
	endfunction
	// aw and w offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
		// one idle edge so a following call never re-raises a strobe in this step
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata; rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// wait for the walk to finish, then confirm ascending order with nothing skipped
	task automatic wait_load();
		while (!cfg_ready) @(posedge aclk);
		`CHK("word count", 11, taken.size())
		for (int i = 0; i < 11 && i < taken.size(); i++)
			`CHK("word addr", 8'h0c + 8'(2 * i), taken[i])
	endtask
	task automatic check_images(input logic f);
		logic [15:0] c, m, n, e, l, d4, d5, d6, d7, t, s;
		c = w(8'h0c, f); m = w(8'h0e, f); n = w(8'h10, f); e = w(8'h12, f); l = w(8'h14, f);
		d4 = w(8'h16, f); d5 = w(8'h18, f); d6 = w(8'h1a, f); d7 = w(8'h1c, f); t = w(8'h1e, f); s = w(8'h20, f);
		`CHK("link cap", {12'h0, c[12], 19'h0}, cfg_link_cap_img)
		`CHK("tl ctrl", {n[15], 1'b0, t[15:12], 13'h0, l[14], 4'h0, l[13], 3'h0, c[15], l[12], c[13], 1'b0},
			cfg_tl_ctrl_img)
		`CHK("cap en", {13'h0, m[15], 5'h0, c[14], 12'h0}, cfg_cap_en_img)
		`CHK("margin", {17'h0, m[14:0]}, cfg_margin_img)
		`CHK("nominal", {1'b0, n[14:0], 16'h0}, cfg_nom_drive_img)
		`CHK("emphasis", {1'b0, e[14:0], 16'h0}, cfg_emphasis_img)
		`CHK("intr pin", {{5{e[15]}}, 1'b0}, irq_pin_req)
		`CHK("param2", {25'h0, l[6:0]}, cfg_phy_param2_img)
		`CHK("param3", {t[11:0], l[11:7], 15'h0}, cfg_phy_param3_img)
		`CHK("phy4", {d5, d4}, cfg_phy4_img)
		`CHK("phy5", {8'h0, d7[7:0], d6}, cfg_phy5_img)
		`CHK("buffer", {8'h0, d7[15:8], 16'h0}, cfg_buffer_img)
		`CHK("fts", s[7:0], port0_fts)
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard, far beyond two loads and a few bus cycles
	initial
	begin
		#20000;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		aresetn = 1'b0; ce = 1'b1; slow = 1'b0; flip = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
		repeat (16) @(posedge aclk);
		`CHK("ready in reset", 1'b0, cfg_ready)
		`CHK("first addr", EE_CAP, ee_rd_addr)
		taken.delete();
		aresetn <= 1'b1;
		wait_load();
		check_images(1'b0);
		// reload with inverted contents and a stalling eeprom
		flip <= 1'b1; slow <= 1'b1;
		@(posedge aclk);
		taken.delete();
		axw(REG_CTRL, 32'h1, r);
		`CHK("ctrl resp", RESP_OKAY, r)
		`CHK("ready reload", 1'b0, cfg_ready)
		// a second reload mid-walk is refused; a restart would break the word log
		axw(REG_CTRL, 32'h1, r);
		`CHK("busy ctrl resp", RESP_OKAY, r)
		// a low enable freezes the walk even though the eeprom keeps answering
		ce <= 1'b0;
		@(posedge aclk);
		d[7:0] = ee_rd_addr;
		repeat (4) @(posedge aclk);
		`CHK("frozen addr", d[7:0], ee_rd_addr)
		ce <= 1'b1;
		wait_load();
		check_images(1'b1);
		axr(REG_STATUS, d, r);
		`CHK("status", 3'b100, d[2:0])
		axr(REG_LAST, d, r);
		`CHK("last word", w(8'h20, 1'b1), d[15:0])
		axr(8'h0c, d, r);
		`CHK("unmapped rd", {RESP_SLV, 32'h0}, {r, d})
		axw(8'h10, 32'h1, r);
		`CHK("unmapped wr", RESP_SLV, r)
		report_and_stop();
	end
endmodule
